// ==== common/ssrp_regs.vh ====
// Register map, field positions and timing constants of the sensor serial register port
`ifndef SSRP_REGS_VH
`define SSRP_REGS_VH
`define SSRP_ADDR_CFG       7'h00
`define SSRP_ADDR_STATUS    7'h01
`define SSRP_ADDR_MOT_Y     7'h02
`define SSRP_ADDR_MOT_X     7'h03
`define SSRP_ADDR_SURF      7'h04
`define SSRP_ADDR_BRIGHT    7'h05
`define SSRP_ADDR_DARK      7'h06
`define SSRP_ADDR_PIXSUM    7'h07
`define SSRP_ADDR_DUMP      7'h08
`define SSRP_ADDR_EXP_HI    7'h09
`define SSRP_ADDR_EXP_LO    7'h0A
`define SSRP_ADDR_INV_ID    7'h11
`define SSRP_CFG_RESET_VAL  8'h00
`define SSRP_CFG_RST_BIT    7
`define SSRP_CFG_SLEEP_BIT  6
`define SSRP_ZERO_BYTE      8'h00
`define SSRP_BITS_PER_XACT  5'h10
`define SSRP_ADDR_BITS_END  5'h08
`define SSRP_CLK_HZ         10000000
`define SSRP_SPTT_MS        90
`define SSRP_SETTLE_FRAMES  3
`endif

// ==== hdl/ssrp_sync.v ====
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/10ps
module ssrp_sync (
    input  wire clk_in,    // Sampling clock
    input  wire rst_b_in,  // Async reset, active low
    input  wire d_in,      // Asynchronous level
    output reg  q_out      // Synchronised level
);
    reg meta_q;

    // First flop feeds only the second one
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // ssrp_sync

// ==== hdl/ssrp_port.v ====
// Two-wire half-duplex serial register port of an optical motion sensor
`timescale 1ns/10ps
`include "ssrp_regs.vh"
// Summary of operation
// - After last read bit, keep presenting it until next falling port clock edge.
// - After a write transaction, data pin stays an input, released.
// - Configuration write that sets sleep releases the data line; later reads still drive it.
// - Transaction not done 90 ms after first rising edge resets the port machine.
// - Writes to unmapped addresses are ignored and change nothing.
// - Reads from unmapped addresses return zero.
// - Device drives data only in reads, from rising edge after address.
// - Device releases data line within 160 ns of falling edge after last bit; the code takes up to three core clocks (300 ns).
// - Idle rising edge samples direction bit: low read, high write.
// - In a read, drive data within 250 ns after seventh address bit; the code drives up to three core clocks after the next rising edge.
// - Power-on reset resets the whole device.
// - Writing reset bit resets device, keeps other bits, self-clears reset bit.
// - After soft reset analog section needs three frames to settle.
// - Decoder maps config, status, data registers 0x02..0x0A, inverted id 0x11.
// - Config bit 6 is analog sleep; config resets to zero.
// - Two bytes: direction bit, seven address bits, then data byte.
// - Driver changes data on falling edges, but the device puts out the first read bit on a rising edge; receiver samples on rising edges.
// - While asleep, configuration write updates only the sleep bit.
module ssrp_port #(
    parameter SPTT_CYCLES = (`SSRP_CLK_HZ / 1000) * `SSRP_SPTT_MS, // Transaction timeout
    parameter [3:0] SETTLE_FRAMES = `SSRP_SETTLE_FRAMES,           // Analog settle frames
    parameter [7:0] PART_ID   = 8'h05   // Arbitrary identity value
) (
    input  wire       CLK_IN,          // 10 MHz core clock
    input  wire       RST_B_IN,        // Power-on reset, async, active low
    input  wire       SCK_IN,          // Port clock from host
    input  wire       SDIO_IN,         // Data line level seen at pin
    output reg        SDIO_OUT,        // Data line drive value
    output reg        SDIO_OE_B_OUT,   // Data line enable, low while driving
    input  wire [7:0] MOT_Y_IN,        // Motion Y count from core
    input  wire [7:0] MOT_X_IN,        // Motion X count from core
    input  wire [7:0] SURF_IN,         // Surface feature measure
    input  wire [7:0] BRIGHT_IN,       // Brightest pixel
    input  wire [7:0] DARK_IN,         // Darkest pixel
    input  wire [7:0] PIXSUM_IN,       // Pixel total upper
    input  wire [7:0] DUMP_IN,         // Image dump port read data
    input  wire [7:0] EXP_HI_IN,       // Exposure high
    input  wire [7:0] EXP_LO_IN,       // Exposure low
    input  wire       AWAKE_IN,        // Core awake state
    input  wire       FRAME_IN,        // Frame tick from core, same clock
    output reg        MOT_Y_CLR_OUT,   // Pulse: motion Y read, clear it
    output reg        MOT_X_CLR_OUT,   // Pulse: motion X read, clear it
    output reg        DUMP_RD_OUT,     // Pulse: image dump port read
    output reg        DUMP_WR_OUT,     // Pulse: image dump port written
    output reg  [7:0] CFG_OUT,         // Configuration register contents
    output reg        SOFT_RST_OUT,    // Pulse: soft reset of core logic
    output reg        ANALOG_READY_OUT // Analog section settled
);
    localparam ST_ADDR = 2'h0;
    localparam ST_WDAT = 2'h1;
    localparam ST_RDAT = 2'h2;

    wire       sck_s;
    wire       sdio_s;
    reg        sck_prev_q;
    reg [1:0]  st_q;
    reg [4:0]  bitcnt_q;
    reg [7:0]  shift_q;
    reg [6:0]  addr_q;
    reg [7:0]  rdata;
    reg [31:0] timer_q;
    reg        busy_q;
    reg [3:0]  settle_q;
    wire       rise = sck_s & ~sck_prev_q;
    wire       fall = ~sck_s & sck_prev_q;
    wire       timeout = busy_q && (timer_q >= SPTT_CYCLES - 1);

    // Port clock and data come from the host's domain
    ssrp_sync u_sync_sck (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (SCK_IN),
        .q_out    (sck_s)
    );
    ssrp_sync u_sync_sdio (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .d_in     (SDIO_IN),
        .q_out    (sdio_s)
    );

    // Read data mux; unmapped addresses read zero
    always @* begin
        if (addr_q == `SSRP_ADDR_CFG) begin
            rdata = CFG_OUT;
        end else if (addr_q == `SSRP_ADDR_STATUS) begin
            rdata = {PART_ID[2:0], 4'h0, AWAKE_IN};
        end else if (addr_q == `SSRP_ADDR_MOT_Y) begin
            rdata = MOT_Y_IN;
        end else if (addr_q == `SSRP_ADDR_MOT_X) begin
            rdata = MOT_X_IN;
        end else if (addr_q == `SSRP_ADDR_SURF) begin
            rdata = SURF_IN;
        end else if (addr_q == `SSRP_ADDR_BRIGHT) begin
            rdata = BRIGHT_IN;
        end else if (addr_q == `SSRP_ADDR_DARK) begin
            rdata = DARK_IN;
        end else if (addr_q == `SSRP_ADDR_PIXSUM) begin
            rdata = PIXSUM_IN;
        end else if (addr_q == `SSRP_ADDR_DUMP) begin
            rdata = DUMP_IN;
        end else if (addr_q == `SSRP_ADDR_EXP_HI) begin
            rdata = EXP_HI_IN;
        end else if (addr_q == `SSRP_ADDR_EXP_LO) begin
            rdata = EXP_LO_IN;
        end else if (addr_q == `SSRP_ADDR_INV_ID) begin
            rdata = ~PART_ID;
        end else begin
            rdata = `SSRP_ZERO_BYTE;
        end
    end

    // Transaction timer counts from the first rising edge of a transaction
    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            timer_q    <= 32'h0;
            busy_q     <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            if (timeout || (st_q == ST_ADDR && bitcnt_q == 5'h0 && !rise)) begin
                timer_q <= 32'h0;
                busy_q  <= 1'b0;
            end else if (rise && !busy_q) begin
                busy_q  <= 1'b1;
                timer_q <= 32'h0;
            end else if (busy_q) begin
                timer_q <= timer_q + 32'h1;
            end
        end
    end

    // Serial state machine; host changes data on falling, we sample on rising
    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_q          <= ST_ADDR;
            bitcnt_q      <= 5'h0;
            shift_q       <= 8'h00;
            addr_q        <= 7'h00;
            SDIO_OUT      <= 1'b0;
            SDIO_OE_B_OUT <= 1'b1;
            CFG_OUT       <= `SSRP_CFG_RESET_VAL;
            SOFT_RST_OUT  <= 1'b0;
            MOT_Y_CLR_OUT <= 1'b0;
            MOT_X_CLR_OUT <= 1'b0;
            DUMP_RD_OUT   <= 1'b0;
            DUMP_WR_OUT   <= 1'b0;
        end else begin
            MOT_Y_CLR_OUT <= 1'b0;
            MOT_X_CLR_OUT <= 1'b0;
            DUMP_RD_OUT   <= 1'b0;
            DUMP_WR_OUT   <= 1'b0;
            SOFT_RST_OUT  <= 1'b0;
            // Reset bit clears itself one cycle after it was written
            if (CFG_OUT[`SSRP_CFG_RST_BIT]) begin
                CFG_OUT[`SSRP_CFG_RST_BIT] <= 1'b0;
            end
            if (timeout) begin
                st_q          <= ST_ADDR;
                bitcnt_q      <= 5'h0;
                SDIO_OE_B_OUT <= 1'b1;
            end else begin
                case (st_q)
                    ST_ADDR: begin
                        if (fall) begin
                            SDIO_OE_B_OUT <= 1'b1;
                        end
                        if (rise) begin
                            // First rising edge is the direction bit
                            shift_q  <= {shift_q[6:0], sdio_s};
                            bitcnt_q <= bitcnt_q + 5'h1;
                            if (bitcnt_q == `SSRP_ADDR_BITS_END - 5'h1) begin
                                addr_q <= {shift_q[5:0], sdio_s};
                                if (shift_q[6]) begin
                                    st_q <= ST_WDAT;
                                end else begin
                                    st_q <= ST_RDAT;
                                end
                            end
                        end
                    end
                    ST_WDAT: begin
                        if (rise) begin
                            shift_q  <= {shift_q[6:0], sdio_s};
                            bitcnt_q <= bitcnt_q + 5'h1;
                            if (bitcnt_q == `SSRP_BITS_PER_XACT - 5'h1) begin
                                st_q     <= ST_ADDR;
                                bitcnt_q <= 5'h0;
                                if (addr_q == `SSRP_ADDR_CFG) begin
                                    if (CFG_OUT[`SSRP_CFG_SLEEP_BIT]) begin
                                        // Data bit n still sits one place lower in the shifter
                                        CFG_OUT[`SSRP_CFG_SLEEP_BIT] <=
                                            shift_q[`SSRP_CFG_SLEEP_BIT - 1];
                                    end else begin
                                        CFG_OUT <= {shift_q[6:0], sdio_s};
                                        SOFT_RST_OUT <= shift_q[6];
                                    end
                                    SDIO_OE_B_OUT <= 1'b1;
                                end else if (addr_q == `SSRP_ADDR_DUMP) begin
                                    DUMP_WR_OUT <= 1'b1;
                                end
                                // Other addresses hold no writable state
                            end
                        end
                    end
                    default: begin
                        // Read: drive from first rising edge after address
                        if (bitcnt_q == `SSRP_ADDR_BITS_END && rise) begin
                            SDIO_OE_B_OUT <= 1'b0;
                            SDIO_OUT      <= rdata[7];
                            shift_q       <= {rdata[6:0], 1'b0};
                            bitcnt_q      <= bitcnt_q + 5'h1;
                            MOT_Y_CLR_OUT <= (addr_q == `SSRP_ADDR_MOT_Y);
                            MOT_X_CLR_OUT <= (addr_q == `SSRP_ADDR_MOT_X);
                            DUMP_RD_OUT   <= (addr_q == `SSRP_ADDR_DUMP);
                        end else if (fall && bitcnt_q != `SSRP_ADDR_BITS_END) begin
                            SDIO_OUT <= shift_q[7];
                            shift_q  <= {shift_q[6:0], 1'b0};
                        end else if (rise) begin
                            bitcnt_q <= bitcnt_q + 5'h1;
                            if (bitcnt_q == `SSRP_BITS_PER_XACT - 5'h1) begin
                                st_q     <= ST_ADDR; // Keeps last bit until fall
                                bitcnt_q <= 5'h0;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Analog section counts frames after soft reset or wake
    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            settle_q         <= 4'h0;
            ANALOG_READY_OUT <= 1'b0;
        end else if (SOFT_RST_OUT || CFG_OUT[`SSRP_CFG_SLEEP_BIT]) begin
            settle_q         <= 4'h0;
            ANALOG_READY_OUT <= 1'b0;
        end else if (FRAME_IN && settle_q < SETTLE_FRAMES) begin
            settle_q         <= settle_q + 4'h1;
            ANALOG_READY_OUT <= (settle_q == SETTLE_FRAMES - 4'h1);
        end else begin
            ANALOG_READY_OUT <= (settle_q >= SETTLE_FRAMES);
        end
    end
endmodule // ssrp_port

// ==== testbench/ssrp_port_props.sv ====
// Concurrent checks on the serial register port pins
`timescale 1ns/10ps
module ssrp_port_props (
    input logic       CLK_IN,          // Core clock
    input logic       RST_B_IN,        // Reset, active low
    input logic       SCK_IN,          // Port clock
    input logic       SDIO_OUT,        // Data drive value
    input logic       SDIO_OE_B_OUT,   // Drive enable, low drives
    input logic       FRAME_IN,        // Frame tick
    input logic       DUMP_WR_OUT,     // Dump port write pulse
    input logic [7:0] CFG_OUT,         // Configuration contents
    input logic       SOFT_RST_OUT,    // Soft reset pulse
    input logic       ANALOG_READY_OUT // Analog settled
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    logic [2:0] frm_q; // Frames since soft reset or wake, saturating
    // Count settle frames; sleep holds it at zero
    always @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) frm_q <= 3'h0;
        else if (SOFT_RST_OUT || CFG_OUT[6]) frm_q <= 3'h0;
        else if (FRAME_IN && frm_q != 3'h7) frm_q <= frm_q + 3'h1;
    end
    sequence rst_pulse; SOFT_RST_OUT ##1 !SOFT_RST_OUT; endsequence
    sequence rst_bit_gone; CFG_OUT[7] ##1 !CFG_OUT[7]; endsequence
    a_drive_after_rise: assert property ($fell(SDIO_OE_B_OUT) |-> SCK_IN)
        else $error("data drive began outside clock high phase");
    a_data_on_fall: assert property ((SDIO_OUT != $past(SDIO_OUT)) && !SDIO_OE_B_OUT
        && !$past(SDIO_OE_B_OUT) |-> !SCK_IN) else $error("data changed while clock high");
    a_release_on_fall: assert property ($rose(SDIO_OE_B_OUT) |-> !SCK_IN)
        else $error("data released while clock high");
    a_write_no_drive: assert property (DUMP_WR_OUT |-> SDIO_OE_B_OUT)
        else $error("line driven after a write");
    a_soft_rst_pulse: assert property (SOFT_RST_OUT |-> rst_pulse)
        else $error("soft reset pulse too long");
    a_rst_bit_clears: assert property (CFG_OUT[7] |-> rst_bit_gone)
        else $error("reset bit did not self clear");
    a_cfg_reset_val: assert property ($rose(RST_B_IN) |-> CFG_OUT == 8'h00)
        else $error("configuration not zero after reset");
    a_ready_settle: assert property ($rose(ANALOG_READY_OUT) |-> frm_q >= 3'h3)
        else $error("analog ready before three frames");
    a_sleep_released: assert property ($rose(CFG_OUT[6]) |-> SDIO_OE_B_OUT)
        else $error("line driven when entering sleep");
endmodule // ssrp_port_props
bind ssrp_port ssrp_port_props u_ssrp_port_props (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
    .SCK_IN(SCK_IN), .SDIO_OUT(SDIO_OUT), .SDIO_OE_B_OUT(SDIO_OE_B_OUT),
    .FRAME_IN(FRAME_IN), .DUMP_WR_OUT(DUMP_WR_OUT), .CFG_OUT(CFG_OUT),
    .SOFT_RST_OUT(SOFT_RST_OUT), .ANALOG_READY_OUT(ANALOG_READY_OUT));

// ==== testbench/ssrp_host.sv ====
// Host master model that clocks frames on the serial port
`timescale 1ns/10ps
module ssrp_host (
    input  logic clk_in,    // Core clock for pacing
    output logic sck_out,   // Port clock
    output logic sdo_out,   // Host data value
    output logic sdo_en_out,// High while host drives
    input  logic sdi_in     // Resolved line level
);
    // Idle high and driven, so no floating pin; the device sees one stray rise after reset
    initial begin
        sck_out = 1'b1;
        sdo_out = 1'b1;
        sdo_en_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Frame of nbits; a short count leaves a partial frame parked low
    task automatic xfer(input int nbits, input logic [15:0] fr, output logic [7:0] rdat);
        int i;
        rdat = 8'h00;
        tick(1000); // Gap covers write and read spacing
        for (i = 0; i < nbits; i++) begin
            if (i == 8 && !fr[15]) begin
                sdo_en_out <= 1'b0; // Let go before the fall
                tick(1000); // Device needs time to fetch data
            end
            sck_out <= 1'b0; // Data moves on falling edges
            if (i < 8 || fr[15]) sdo_out <= fr[15 - i];
            tick(3);
            if (i == 0) sdo_en_out <= 1'b1; // Retake line once device let go
            tick(1);
            sck_out <= 1'b1;
            tick(4);
            if (i >= 8 && !fr[15]) rdat[15 - i] = sdi_in;
        end
        if (nbits < 16) sck_out <= 1'b0;
    endtask
endmodule // ssrp_host

// ==== testbench/ssrp_port_test.sv ====
// Self-checking bench for the serial register port
`timescale 1ns/10ps
module ssrp_port_test;
    localparam logic [7:0] ID = 8'h05; // Arbitrary identity value
    logic       clk = 1'b0;   // Core clock
    logic       rst_b = 1'b0; // Reset, active low
    logic       flt = 1'b0;   // Undriven line pattern
    logic       frame = 1'b0; // Frame tick
    logic [5:0] fcnt = 6'h00; // Frame spacing
    logic [7:0] rv [0:10] = '{default: 8'h00}; // Core register values
    wire        sck, h_d, h_en, sd_o, oe_b, sdio, ready;
    wire  [7:0] cfg;
    wire        clr_y, clr_x, dump_rd, dump_wr;
    logic       awake = 1'b1; // Core awake level
    logic [7:0] n_y = 8'h00;  // Motion Y clear pulses seen
    logic [7:0] n_x = 8'h00;  // Motion X clear pulses seen
    logic [7:0] n_rd = 8'h00; // Dump read pulses seen
    logic [7:0] n_wr = 8'h00; // Dump write pulses seen
    int         errors = 0;
    int         num_checks = 0;
    assign sdio = !oe_b ? sd_o : (h_en ? h_d : flt); // Released line wanders
    always #50 clk = ~clk;
    // Frame tick every 64 clocks; floating pattern toggles
    always @(posedge clk) begin
        fcnt <= fcnt + 6'h01;
        frame <= &fcnt;
        flt <= ~flt;
    end
    // Count one-cycle pulses so tasks can judge them later; outputs are unknown before reset
    always @(posedge clk) begin
        if (rst_b) begin
            n_y  <= n_y + {7'h00, clr_y};
            n_x  <= n_x + {7'h00, clr_x};
            n_rd <= n_rd + {7'h00, dump_rd};
            n_wr <= n_wr + {7'h00, dump_wr};
        end
    end
    ssrp_host u_ssrp_host (.clk_in(clk), .sck_out(sck), .sdo_out(h_d), .sdo_en_out(h_en),
        .sdi_in(sdio));
    ssrp_port #(.SPTT_CYCLES(2000), .PART_ID(ID)) u_ssrp_port (.CLK_IN(clk), .RST_B_IN(rst_b),
        .SCK_IN(sck), .SDIO_IN(sdio), .SDIO_OUT(sd_o), .SDIO_OE_B_OUT(oe_b),
        .MOT_Y_IN(rv[2]), .MOT_X_IN(rv[3]), .SURF_IN(rv[4]), .BRIGHT_IN(rv[5]),
        .DARK_IN(rv[6]), .PIXSUM_IN(rv[7]), .DUMP_IN(rv[8]), .EXP_HI_IN(rv[9]),
        .EXP_LO_IN(rv[10]), .AWAKE_IN(awake), .FRAME_IN(frame), .MOT_Y_CLR_OUT(clr_y),
        .MOT_X_CLR_OUT(clr_x), .DUMP_RD_OUT(dump_rd), .DUMP_WR_OUT(dump_wr), .CFG_OUT(cfg),
        .SOFT_RST_OUT(), .ANALOG_READY_OUT(ready));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        u_ssrp_host.xfer(16, {1'b0, a, 8'h00}, d);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] d;
        u_ssrp_host.xfer(16, {1'b1, a, v}, d);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_ident;
        logic [7:0] d;
        rd(7'h00, d); chk("cfg", 8'h00, d);
        rd(7'h01, d); chk("status", {ID[2:0], 5'h01}, d);
        awake <= 1'b0;
        rd(7'h01, d); chk("asleep status", {ID[2:0], 5'h00}, d);
        awake <= 1'b1;
        rd(7'h11, d); chk("inv id", ~ID, d);
        chk("hold oe", 8'h00, {7'h0, oe_b});
        chk("hold bit", {7'h0, ~ID[0]}, {7'h0, sd_o});
    endtask
    task automatic t_map;
        logic [7:0] d;
        @(posedge clk);
        for (int a = 2; a <= 10; a++) rv[a] <= 8'h30 + 8'(a * 17);
        for (int a = 2; a <= 10; a++) begin
            rd(7'(a), d); chk("map", 8'h30 + 8'(a * 17), d);
        end
        chk("y clears", 8'h01, n_y);
        chk("x clears", 8'h01, n_x);
        chk("dump reads", 8'h01, n_rd);
    endtask
    task automatic t_unmapped;
        logic [7:0] d;
        wr(7'h00, 8'h21);
        wr(7'h12, 8'h5A); chk("cfg keep", 8'h21, cfg);
        u_ssrp_host.tick(2); chk("no dump wr", 8'h00, n_wr);
        wr(7'h08, 8'h00);
        u_ssrp_host.tick(2); chk("dump wr", 8'h01, n_wr);
        rd(7'h12, d); chk("unmapped", 8'h00, d);
        rd(7'h7F, d); chk("unmapped", 8'h00, d);
        rd(7'h00, d); chk("cfg read", 8'h21, d);
    endtask
    task automatic t_sleep;
        wr(7'h00, 8'h61); chk("sleep cfg", 8'h61, cfg);
        chk("sleep oe", 8'h01, {7'h0, oe_b});
        wr(7'h00, 8'h5E); chk("asleep cfg", 8'h61, cfg);
        wr(7'h00, 8'h00); chk("wake cfg", 8'h21, cfg);
        chk("wake oe", 8'h01, {7'h0, oe_b});
    endtask
    task automatic t_soft;
        wr(7'h00, 8'h85);
        // Reset bit stands one cycle before it clears itself
        u_ssrp_host.tick(1); chk("soft cfg", 8'h05, cfg);
        chk("not ready", 8'h00, {7'h0, ready});
        u_ssrp_host.tick(260); chk("ready", 8'h01, {7'h0, ready});
    endtask
    task automatic t_timeout;
        logic [7:0] d;
        u_ssrp_host.xfer(5, 16'hFFFF, d);
        u_ssrp_host.tick(2500);
        u_ssrp_host.xfer(10, 16'h0000, d);
        u_ssrp_host.tick(2500); chk("expiry oe", 8'h01, {7'h0, oe_b});
        rd(7'h00, d); chk("resync", 8'h05, d);
    endtask
    // Watchdog sized well past the expected run
    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        $display("mismatch watchdog expected done seen hang");
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        u_ssrp_host.tick(2500); // Stray startup edge must time out first
        t_ident();
        t_map();
        t_unmapped();
        t_sleep();
        t_soft();
        t_timeout();
        give_verdict();
    end
endmodule // ssrp_port_test
